// [crcs_core_regs.sv]
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// (RULE1) 8-bit accumulator holds operands and results.
// (RULE2) interrupt entry/return never stacks the second index register.
// (RULE3) 16-bit next fetch counter, low and high bytes.
// (RULE4) half carry bit 4 set on carry out of bit 3 by add/adc.
// (RULE5) mask bit 3 set on entry or mask set; cleared by clear or return.
// (RULE6) requests during mask are latched pending, serviced after clearing.
// (RULE7) clearing mask in a handler takes pending requests at once.
// (RULE8) negative bit 2 copies result bit 7.
// (RULE9) zero bit 1 set when result is zero.
// (RULE10) carry bit 0 from arithmetic, set/clear ops, test, shift, rotate.
// (RULE11) flags reset 111x1xxx; bits 7 to 5 read one.
// (RULE12) pointer names next free byte; dec after push, inc before pop.
// (RULE13) ten upper pointer bits fixed; reset and restore load top.
// (RULE14) low pointer byte loadable and readable.
// (RULE15) pointer wraps silently at both ends.
// (RULE16) interrupt entry writes fetch low byte first at pointer.
// (RULE17) call uses two stack bytes, interrupt five.
// (RULE18) order fetch low, fetch high, index, accumulator, flags; reverse on return.
module crcs_core_regs
	import crcs_pkg::*;
#(
	parameter int IRQ_N = 8
) (
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst_b,
	// sequencer commands
	input  wire crcs_cmd_s         cmd,
	input  wire crcs_seq_e         seq,
	input  wire logic [7:0]        push_data,
	input  wire logic              trap,
	// interrupt requests from peripherals, same clock
	input  wire logic [IRQ_N-1:0]  irq,
	input  wire logic [IRQ_N-1:0]  irq_ack,
	// stack memory
	output crcs_mem_s              mem,
	input  wire logic [7:0]        mem_rdata,
	// architectural state
	output logic      [7:0]        accum,
	output logic      [7:0]        index_x,
	output logic      [7:0]        index_y,
	output logic      [15:0]       next_fetch_counter,
	output logic      [7:0]        flag_register,
	output logic      [15:0]       stack_top_pointer,
	output logic      [7:0]        pop_data,
	output logic                   seq_busy,
	output logic                   irq_take,
	output logic      [IRQ_N-1:0]  irq_pending
);
	// ==========================================================
	// stack sequencer
	typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_POP} crcs_st_e;
	crcs_st_e    state;
	crcs_seq_e   kind;
	logic [2:0]  step;
	logic [2:0]  next_step;
	logic [2:0]  n_bytes;
	logic        start;
	logic        is_int;
	logic        sp_dec;
	logic        sp_inc;
	logic        sp_reload;
	logic        sp_load;
	logic [15:0] sp_now;
	logic [7:0]  push_byte;
	logic        pop_take;
	logic        last_step;

	localparam logic [2:0] CTX_N  = 3'(CTX_BYTES);
	localparam logic [2:0] CALL_N = 3'(CALL_BYTES);

	assign start   = (state == ST_IDLE) && (seq != CRCS_SEQ_NONE);
	assign n_bytes = (kind == CRCS_SEQ_INT || kind == CRCS_SEQ_INTERRUPT_RETURN_OP) ? CTX_N :   // RULE17
	                 (kind == CRCS_SEQ_CALL || kind == CRCS_SEQ_RET) ? CALL_N : 3'd1;
	assign is_int  = (kind == CRCS_SEQ_INT) || (kind == CRCS_SEQ_INTERRUPT_RETURN_OP);
	assign last_step = (step == n_bytes - 3'd1);
	assign next_step = last_step ? 3'd0 : step + 3'd1;

	// entry order: fetch low, fetch high, x, accum, flags; y never stacked
	always_comb begin
		push_byte = push_data;
		if (kind == CRCS_SEQ_INT || kind == CRCS_SEQ_CALL) begin
			case (step)
				3'd0:    push_byte = next_fetch_counter[7:0];   // RULE16 RULE18
				3'd1:    push_byte = next_fetch_counter[15:8];  // RULE18
				3'd2:    push_byte = index_x;                   // RULE2 RULE18
				3'd3:    push_byte = accum;                     // RULE18
				default: push_byte = flag_register;             // RULE18
			endcase
		end
	end

	// pop runs in two phases per byte: pointer first, then read
	logic pop_phase;
	assign sp_dec    = (state == ST_PUSH);                      // RULE12
	assign sp_inc    = (state == ST_POP) && !pop_phase;         // RULE12
	assign pop_take  = (state == ST_POP) && pop_phase;
	assign sp_reload = (cmd.op == CRCS_OP_STACK_RESTORE);       // RULE13
	assign sp_load   = (cmd.op == CRCS_OP_LOAD_SP);             // RULE14

	crcs_stack_ptr u_sp (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.reload   (sp_reload),
		.load     (sp_load),
		.load_val (cmd.data),
		.dec      (sp_dec),
		.inc      (sp_inc),
		.ptr      (sp_now)
	);

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state     <= ST_IDLE;
			kind      <= CRCS_SEQ_NONE;
			step      <= 3'd0;
			pop_phase <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					step      <= 3'd0;
					pop_phase <= 1'b0;
					if (start) begin
						kind  <= seq;
						state <= (seq == CRCS_SEQ_RET || seq == CRCS_SEQ_INTERRUPT_RETURN_OP ||
						          seq == CRCS_SEQ_POP) ? ST_POP : ST_PUSH;
					end
				end
				ST_PUSH: begin
					step <= next_step;
					if (last_step) state <= ST_IDLE;
				end
				ST_POP: begin
					pop_phase <= !pop_phase;
					if (pop_phase) begin
						step <= next_step;
						if (last_step) state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// memory port, registered
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mem      <= '0;
			seq_busy <= 1'b0;
		end else begin
			mem.wr    <= (state == ST_PUSH);
			mem.rd    <= pop_take;
			// pointer has already moved up on the pop's first phase
			mem.addr  <= sp_now;
			mem.wdata <= push_byte;
			seq_busy  <= start || (state != ST_IDLE && !(last_step &&
			             (state == ST_PUSH || pop_phase)));
		end
	end

	// pop data comes back one cycle after the read strobe
	logic       rd_q;
	logic [2:0] rd_step;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_q    <= 1'b0;
			rd_step <= 3'd0;
		end else begin
			rd_q    <= pop_take;
			rd_step <= step;
		end
	end

	// data stands the cycle after the strobe, so the step tag follows it
	logic rd_fire;
	logic [2:0] pop_step_d;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_fire    <= 1'b0;
			pop_step_d <= 3'd0;
		end else begin
			rd_fire    <= rd_q;
			pop_step_d <= rd_step;
		end
	end

	// interrupt return pops flags, accum, x, fetch high, fetch low; ret pops fetch high, fetch low
	logic pop_flags, pop_acc, pop_x, pop_pch, pop_pcl;
	logic pop_ctx;
	assign pop_ctx   = rd_fire && (kind == CRCS_SEQ_INTERRUPT_RETURN_OP);
	logic pop_ret;
	assign pop_ret   = rd_fire && (kind == CRCS_SEQ_RET);
	assign pop_flags = pop_ctx && (pop_step_d == 3'd0);                 // RULE18
	assign pop_acc   = pop_ctx && (pop_step_d == 3'd1);                 // RULE18
	assign pop_x     = pop_ctx && (pop_step_d == 3'd2);                 // RULE2
	assign pop_pch   = (pop_ctx && pop_step_d == 3'd3) || (pop_ret && pop_step_d == 3'd0);
	assign pop_pcl   = (pop_ctx && pop_step_d == 3'd4) || (pop_ret && pop_step_d == 3'd1);

	// ==========================================================
	// data registers and flags
	logic [8:0] sum;
	logic [4:0] half;
	logic [7:0] result;
	logic       add_op;
	logic       res_op;
	logic       cin;
	assign cin    = (cmd.op == CRCS_OP_ADC) && flag_register[BIT_C];
	assign sum    = {1'b0, accum} + {1'b0, cmd.data} + {8'h00, cin};
	assign half   = {1'b0, accum[NIB-1:0]} + {1'b0, cmd.data[NIB-1:0]} + {4'h0, cin};
	assign add_op = (cmd.op == CRCS_OP_ADD) || (cmd.op == CRCS_OP_ADC);
	assign res_op = (cmd.op == CRCS_OP_RESULT) || (cmd.op == CRCS_OP_LOAD_A);
	assign result = add_op ? sum[7:0] : cmd.data;

	logic [7:0] next_flags;
	always_comb begin
		next_flags = flag_register;
		if (add_op) begin
			next_flags[BIT_H] = half[NIB];                       // RULE4
			next_flags[BIT_C] = sum[DATA_W];                     // RULE10
		end
		if (add_op || res_op) begin
			next_flags[BIT_N] = result[MSB];                     // RULE8
			next_flags[BIT_Z] = (result == 8'h00);               // RULE9
		end
		case (cmd.op)
			CRCS_OP_CARRY_SET:   next_flags[BIT_C] = 1'b1;       // RULE10
			CRCS_OP_CARRY_CLEAR: next_flags[BIT_C] = 1'b0;       // RULE10
			CRCS_OP_CARRY_LOAD:  next_flags[BIT_C] = cmd.carry_in; // RULE10
			CRCS_OP_MASK_SET:    next_flags[BIT_I] = 1'b1;       // RULE5
			CRCS_OP_MASK_CLEAR:  next_flags[BIT_I] = 1'b0;       // RULE5 RULE7
			CRCS_OP_LOAD_FLAGS:  next_flags = cmd.data;
			default:             next_flags = next_flags;
		endcase
		if (pop_flags) next_flags = mem_rdata;
		if (start && seq == CRCS_SEQ_INT) next_flags[BIT_I] = 1'b1;      // RULE5
		if (pop_flags) next_flags[BIT_I] = 1'b0;                          // RULE5
		next_flags = next_flags | FLAGS_FIXED;                            // RULE11
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			accum              <= 8'h00;
			index_x            <= 8'h00;
			index_y            <= 8'h00;
			next_fetch_counter <= 16'h0000;
			flag_register      <= FLAGS_RST;                              // RULE11
			pop_data           <= 8'h00;
		end else begin
			flag_register <= next_flags;
			if (add_op || cmd.op == CRCS_OP_LOAD_A) accum <= result;      // RULE1
			else if (pop_acc) accum <= mem_rdata;
			if (cmd.op == CRCS_OP_LOAD_X) index_x <= cmd.data;
			else if (pop_x) index_x <= mem_rdata;
			if (cmd.op == CRCS_OP_LOAD_Y) index_y <= cmd.data;
			if (pop_pch) next_fetch_counter[15:8] <= mem_rdata;           // RULE3
			else if (state == ST_IDLE && !rd_q && !rd_fire)
				next_fetch_counter <= cmd.fetch;                          // RULE3
			if (pop_pcl) next_fetch_counter[7:0] <= mem_rdata;            // RULE3
			if (rd_fire) pop_data <= mem_rdata;
		end
	end

	// ==========================================================
	// interrupt latch; a new request beats an acknowledge
	logic [IRQ_N-1:0] next_pend;
	assign next_pend = (irq_pending & ~irq_ack) | irq;                    // RULE6
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_pending <= '0;
			irq_take    <= 1'b0;
			stack_top_pointer <= SP_TOP;
		end else begin
			irq_pending <= next_pend;
			// taken the cycle the mask reads clear, whatever handler runs
			irq_take    <= trap || ((|next_pend) && !next_flags[BIT_I]);  // RULE6 RULE7
			stack_top_pointer <= sp_now;                                  // RULE13 RULE15
		end
	end

	// ==========================================================
	// checks
	fixed_bits_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		flag_register[7:5] == 3'b111) else $error("fixed flag bits not one"); // RULE11
	sp_range_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		stack_top_pointer[15:6] == SP_HARD[15:6]) else $error("pointer upper bits moved"); // RULE13
	mask_entry_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		start && seq == CRCS_SEQ_INT |=> flag_register[BIT_I]) else $error("mask not set"); // RULE5
	sequence s_pcl_first;
		mem.wr && mem.wdata == $past(next_fetch_counter[7:0], 1);
	endsequence
	int_first_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		state == ST_IDLE && start && seq == CRCS_SEQ_INT |=> ##1 s_pcl_first)
		else $error("interrupt did not push fetch low first"); // RULE16
	int_five_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		$rose(mem.wr) && kind == CRCS_SEQ_INT |-> mem.wr[*5] ##1 !mem.wr)
		else $error("interrupt push not five bytes"); // RULE17
	zero_flag_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		res_op && !pop_flags |=> flag_register[BIT_Z] == ($past(cmd.data) == 8'h00))
		else $error("zero flag wrong"); // RULE9
	neg_flag_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		res_op && !pop_flags |=> flag_register[BIT_N] == $past(cmd.data[MSB]))
		else $error("negative flag wrong"); // RULE8
	pend_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		|irq |=> (irq_pending & $past(irq)) == $past(irq)) else $error("request not latched"); // RULE6
	push_dec_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		state == ST_PUSH |=> sp_now[5:0] == $past(sp_now[5:0]) - 6'd1)
		else $error("pointer not decremented"); // RULE12
	restore_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		sp_reload |=> ##1 stack_top_pointer == SP_TOP) else $error("restore failed"); // RULE13
endmodule // crcs_core_regs
`default_nettype wire

// [crcs_pkg.sv]
`default_nettype none
package crcs_pkg;
	localparam int          DATA_W      = 8;
	localparam int          ADDR_W      = 16;
	localparam int          SP_LOW_W    = 6;
	localparam int          CTX_BYTES   = 5;
	localparam int          CALL_BYTES  = 2;
	localparam logic [15:0] SP_TOP      = 16'h00ff;
	localparam logic [15:0] SP_HARD     = 16'h00c0;
	localparam logic [7:0]  FLAGS_FIXED = 8'he0;
	localparam logic [7:0]  FLAGS_RST   = 8'he8;
	localparam int          BIT_H       = 4;
	localparam int          BIT_I       = 3;
	localparam int          BIT_N       = 2;
	localparam int          BIT_Z       = 1;
	localparam int          BIT_C       = 0;
	localparam int          MSB         = 7;
	localparam int          NIB         = 4;

	typedef enum logic [3:0] {
		CRCS_OP_NONE, CRCS_OP_LOAD_A, CRCS_OP_LOAD_X, CRCS_OP_LOAD_Y, CRCS_OP_LOAD_SP,
		CRCS_OP_LOAD_FLAGS, CRCS_OP_ADD, CRCS_OP_ADC, CRCS_OP_RESULT,
		CRCS_OP_MASK_SET, CRCS_OP_MASK_CLEAR, CRCS_OP_CARRY_SET, CRCS_OP_CARRY_CLEAR,
		CRCS_OP_CARRY_LOAD, CRCS_OP_STACK_RESTORE
	} crcs_op_e;

	typedef enum logic [2:0] {
		CRCS_SEQ_NONE, CRCS_SEQ_CALL, CRCS_SEQ_RET, CRCS_SEQ_INT, CRCS_SEQ_INTERRUPT_RETURN_OP,
		CRCS_SEQ_PUSH, CRCS_SEQ_POP
	} crcs_seq_e;

	typedef struct packed {
		crcs_op_e    op;
		logic [7:0]  data;
		logic        carry_in;
		logic [15:0] fetch;
	} crcs_cmd_s;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} crcs_mem_s;
endpackage
`default_nettype wire

// [crcs_stack_ptr.sv]
`timescale 1ns/10ps
`default_nettype none
module crcs_stack_ptr
	import crcs_pkg::*;
(
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst_b,
	// control
	input  wire logic              reload,
	input  wire logic              load,
	input  wire logic [7:0]        load_val,
	input  wire logic              dec,
	input  wire logic              inc,
	// state
	output logic      [15:0]       ptr
);
	logic [SP_LOW_W-1:0] low;
	logic [SP_LOW_W-1:0] next_low;

	// six live bits; the wrap at both ends falls out of the width
	assign next_low = reload ? SP_TOP[SP_LOW_W-1:0] :
	                  load   ? load_val[SP_LOW_W-1:0] :
	                  dec    ? low - 1'b1 :
	                  inc    ? low + 1'b1 : low;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			low <= SP_TOP[SP_LOW_W-1:0];
		end else begin
			low <= next_low;
		end
	end

	assign ptr = SP_HARD | {10'h000, low};
endmodule // crcs_stack_ptr
`default_nettype wire

// [crcs_core_regs_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module crcs_core_regs_tb;
	import crcs_pkg::*;
	// ==========================================
	// design hookup
	logic        core_clk;
	logic        rst_b;
	crcs_cmd_s   cmd;
	crcs_seq_e   seq;
	logic [7:0]  push_data;
	logic        trap;
	logic [7:0]  irq;
	logic [7:0]  irq_ack;
	crcs_mem_s   mem;
	logic [7:0]  mem_rdata;
	logic [7:0]  accum, index_x, index_y, flag_register, pop_data, irq_pending;
	logic [15:0] next_fetch_counter, stack_top_pointer;
	logic        seq_busy, irq_take;
	int          errors, compares;
	int          m_a, m_x, m_y, m_f, m_sp;
	logic [15:0] rnd, fv;
	logic [7:0]  ctx [5];
	logic [7:0]  stk [256];
	crcs_mem_s   wr_q [$];

	crcs_core_regs #(.IRQ_N(8)) i_dut (
		.core_clk(core_clk), .rst_b(rst_b), .cmd(cmd), .seq(seq),
		.push_data(push_data), .trap(trap), .irq(irq), .irq_ack(irq_ack),
		.mem(mem), .mem_rdata(mem_rdata), .accum(accum), .index_x(index_x),
		.index_y(index_y), .next_fetch_counter(next_fetch_counter),
		.flag_register(flag_register), .stack_top_pointer(stack_top_pointer),
		.pop_data(pop_data), .seq_busy(seq_busy), .irq_take(irq_take),
		.irq_pending(irq_pending)
	);

	always #2.5 core_clk = ~core_clk;

	// ==========================================
	// stack memory; unread cycles toggle the data so stale bytes never match
	always @(posedge core_clk) begin
		if (mem.wr === 1'b1) begin
			stk[mem.addr[7:0]] <= mem.wdata;
			wr_q.push_back(mem);
		end
		mem_rdata <= (mem.rd === 1'b1) ? stk[mem.addr[7:0]] : ~mem_rdata;
	end

	// ==========================================
	// helpers
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic int nz(input int r);
		return (r[7] ? 4 : 0) | (r[7:0] == 0 ? 2 : 0);
	endfunction

	task automatic print_verdict();
		if (errors == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic check_reg(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic check_mem(input logic [15:0] a, input logic [7:0] d);
		crcs_mem_s w;
		compares++;
		w = (wr_q.size() > 0) ? wr_q.pop_front() : '0;
		if ({w.addr, w.wdata} !== {a, d}) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, {w.addr, w.wdata}, {a, d});
		end
	endtask

	task automatic do_op(input crcs_op_e op, input logic [7:0] d, input logic ci);
		@(posedge core_clk);
		cmd.op <= op;
		cmd.data <= d;
		cmd.carry_in <= ci;
		@(posedge core_clk);
		cmd.op <= CRCS_OP_NONE;
		#1;
	endtask

	task automatic run_seq(input crcs_seq_e s, input logic [7:0] pd);
		int n;
		@(posedge core_clk);
		seq <= s;
		push_data <= pd;
		@(posedge core_clk);
		seq <= CRCS_SEQ_NONE;
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (seq_busy !== 1'b0 && n < 40);
		repeat (3) @(posedge core_clk);
		#1;
		check_reg({15'h0, seq_busy}, 16'h0000);
	endtask

	// the visible pointer trails the live one by a cycle
	task automatic check_sp(input logic [15:0] exp);
		@(posedge core_clk);
		#1;
		check_reg(stack_top_pointer, exp);
	endtask

	task automatic wait_take();
		int n;
		n = 0;
		while (irq_take !== 1'b1 && n < 4) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		check_reg({15'h0, irq_take}, 16'h0001);
	endtask

	task automatic add_op(input logic [7:0] d, input logic adc);
		int ci;
		int s;
		int h;
		ci = adc ? (m_f & 1) : 0;
		s = m_a + d + ci;
		h = (m_a & 15) + (d & 15) + ci;
		do_op(adc ? CRCS_OP_ADC : CRCS_OP_ADD, d, ci[0]);
		m_a = s & 255;
		m_f = (m_f & 'he8) | (h > 15 ? 16 : 0) | nz(m_a) | (s > 255 ? 1 : 0);
		check_reg(16'(m_a), {8'h00, accum});
		check_reg(16'(m_f), {8'h00, flag_register});
	endtask

	// ==========================================
	// watchdog, far beyond the few hundred cycles the run needs
	initial begin
		#100000;
		errors++;
		print_verdict();
	end

	// ==========================================
	// main sequence
	initial begin
		crcs_op_e   ops [7];
		logic [7:0] dat [7];
		logic [7:0] la [4];
		logic [7:0] lb [4];
		ops = '{CRCS_OP_MASK_CLEAR, CRCS_OP_CARRY_SET, CRCS_OP_RESULT, CRCS_OP_CARRY_CLEAR,
			CRCS_OP_RESULT, CRCS_OP_CARRY_LOAD, CRCS_OP_MASK_SET};
		dat = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
		la = '{8'h0f, 8'hff, 8'h80, 8'h00};
		lb = '{8'h01, 8'h01, 8'h80, 8'h00};
		errors = 0;
		compares = 0;
		rnd = 16'd64143;
		core_clk = 1'b0;
		rst_b = 1'b0;
		cmd = '0;
		fv = lfsr(rnd);
		cmd.fetch = fv;
		seq = CRCS_SEQ_NONE;
		push_data = 8'h00;
		trap = 1'b0;
		irq = 8'h00;
		irq_ack = 8'h00;
		mem_rdata = 8'h00;
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		#1;
		m_a = 0;
		m_f = 'he8;
		check_reg({8'h00, flag_register & 8'he8}, 16'h00e8);
		check_reg(stack_top_pointer, 16'h00ff);
		// boundary sums first, then random ones
		for (int i = 0; i < 20; i++) begin
			rnd = lfsr(rnd);
			do_op(CRCS_OP_LOAD_A, i < 4 ? la[i] : rnd[7:0], 1'b0);
			m_a = i < 4 ? la[i] : rnd[7:0];
			check_reg(16'(m_a), {8'h00, accum});
			add_op(i < 4 ? lb[i] : rnd[15:8], rnd[0] & (i > 3));
		end
		foreach (ops[i]) begin
			do_op(ops[i], dat[i], 1'b1);
			case (ops[i])
				CRCS_OP_MASK_CLEAR:                    m_f = m_f & ~8;
				CRCS_OP_MASK_SET:                      m_f = m_f | 8;
				CRCS_OP_CARRY_SET, CRCS_OP_CARRY_LOAD: m_f = m_f | 1;
				CRCS_OP_CARRY_CLEAR:                   m_f = m_f & ~1;
				default:                               m_f = (m_f & ~6) | nz(dat[i]);
			endcase
			check_reg(16'(m_f), {8'h00, flag_register});
		end
		do_op(CRCS_OP_LOAD_SP, 8'h05, 1'b0);
		check_sp(16'h00c5);
		do_op(CRCS_OP_STACK_RESTORE, 8'h00, 1'b0);
		check_sp(16'h00ff);
		run_seq(CRCS_SEQ_CALL, 8'h00);
		check_mem(16'h00ff, fv[7:0]);
		check_mem(16'h00fe, fv[15:8]);
		check_reg(stack_top_pointer, 16'h00fd);
		run_seq(CRCS_SEQ_RET, 8'h00);
		check_reg(stack_top_pointer, 16'h00ff);
		check_reg(next_fetch_counter, fv);
		// a one-cycle request under mask must stay latched
		m_a = 8'h3c;
		m_x = 8'hc3;
		m_y = 8'h96;
		do_op(CRCS_OP_LOAD_A, 8'h3c, 1'b0);
		do_op(CRCS_OP_LOAD_X, 8'hc3, 1'b0);
		do_op(CRCS_OP_LOAD_Y, 8'h96, 1'b0);
		do_op(CRCS_OP_RESULT, 8'h00, 1'b0);
		m_f = (m_f & ~6) | 2;
		@(posedge core_clk);
		irq[2] <= 1'b1;
		@(posedge core_clk);
		irq[2] <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		check_reg({8'h00, irq_pending}, 16'h0004);
		check_reg({15'h0, irq_take}, 16'h0000);
		do_op(CRCS_OP_MASK_CLEAR, 8'h00, 1'b0);
		m_f = m_f & ~8;
		wait_take();
		ctx = '{fv[7:0], fv[15:8], m_x[7:0], m_a[7:0], m_f[7:0] | 8'h08};
		wr_q.delete();
		run_seq(CRCS_SEQ_INT, 8'h00);
		foreach (ctx[k]) check_mem(16'h00ff - 16'(k), ctx[k]);
		check_reg(stack_top_pointer, 16'h00fa);
		check_reg({8'h00, flag_register & 8'h08}, 16'h0008);
		@(posedge core_clk);
		irq_ack[2] <= 1'b1;
		@(posedge core_clk);
		irq_ack[2] <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		check_reg({8'h00, irq_pending}, 16'h0000);
		do_op(CRCS_OP_LOAD_A, 8'h11, 1'b0);
		do_op(CRCS_OP_LOAD_X, 8'h22, 1'b0);
		run_seq(CRCS_SEQ_INTERRUPT_RETURN_OP, 8'h00);
		check_reg({accum, index_x}, {m_a[7:0], m_x[7:0]});
		check_reg({index_y, flag_register}, {m_y[7:0], m_f[7:0]});
		check_reg(stack_top_pointer, 16'h00ff);
		// the software trap ignores the mask
		do_op(CRCS_OP_MASK_SET, 8'h00, 1'b0);
		@(posedge core_clk);
		trap <= 1'b1;
		wait_take();
		@(posedge core_clk);
		trap <= 1'b0;
		do_op(CRCS_OP_LOAD_SP, 8'h00, 1'b0);
		check_sp(16'h00c0);
		wr_q.delete();
		rnd = lfsr(rnd);
		run_seq(CRCS_SEQ_PUSH, rnd[7:0]);
		check_mem(16'h00c0, rnd[7:0]);
		check_reg(stack_top_pointer, 16'h00ff);
		run_seq(CRCS_SEQ_POP, 8'h00);
		check_reg(stack_top_pointer, 16'h00c0);
		check_reg({8'h00, pop_data}, {8'h00, rnd[7:0]});
		print_verdict();
	end
endmodule // crcs_core_regs_tb
`default_nettype wire
